// file: sim/hcs_host_model.sv
// host controller model: sends one request and takes its reply
`timescale 1ns/10ps
module hcs_host_model (
	input  wire logic              mclk, // clock
	input  wire hcs_pkg::hcs_rsp_t rsp,  // reply from block
	output hcs_pkg::hcs_req_t      req   // request to block
);
	import hcs_pkg::*;
	initial req = '0;
	// released fields are inverted so stale values never look valid
	task automatic xfer(input logic [7:0] ch, input logic [7:0] cmd, output hcs_rsp_t r);
		@(posedge mclk);
		#1 req = '{1'b1, ch, cmd};
		@(posedge mclk);
		#1 req = '{1'b0, ~ch, ~cmd};
		r = rsp;
	endtask
endmodule // hcs_host_model

// file: sim/hcs_top_assertions.sv
// concurrent checks on the channel service command interpreter ports
`timescale 1ns/10ps
module hcs_top_chk #(
	parameter logic [hcs_pkg::HCS_TMR_W-1:0] SUSP_CYCLES = hcs_pkg::HCS_SUSP_CYCLES
) (
	input wire logic                        mclk,         // clock
	input wire logic                        arst_n,       // reset, active low
	input wire logic                        ce,           // clock enable
	input wire hcs_pkg::hcs_req_t           req,          // request
	input wire hcs_pkg::hcs_chan_t          chan_st,      // channel state
	input wire logic [hcs_pkg::HCS_NCH-1:0] oimg_suspend, // image bits
	input wire logic [hcs_pkg::HCS_NCH-1:0] cfg_change,   // config pulses
	input wire logic [hcs_pkg::HCS_NCH-1:0] passthru_req, // pass-through
	input wire hcs_pkg::hcs_rsp_t           rsp,          // reply
	input wire logic [hcs_pkg::HCS_NCH-1:0] ch_suspended, // halted channels
	input wire logic [hcs_pkg::HCS_NCH-1:0] ch_fp_reset   // field reset
);
	import hcs_pkg::*;
	// wide count so the full three-minute period does not overflow
	localparam longint LIM = longint'(SUSP_CYCLES) + 64'd4;
	logic [1:0] c;
	logic [3:0] lk;
	logic [3:0] ok;
	longint     n_q;
	longint     n_d;
	assign c = req.chan[1:0];
	assign lk = chan_st.enabled & chan_st.linked;
	assign ok = lk & ~chan_st.gathering;
	// ch0 suspended time since last reload; any request counts as one
	always_comb begin
		n_d = !ce ? n_q : (ch_suspended[0] && !req.valid && !passthru_req[0]) ? n_q + 1 : 0;
	end
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n)
			n_q <= 0;
		else
			n_q <= n_d;
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);
	sequence s_req(logic [7:0] k);
		ce && req.valid && req.cmd == k && req.chan <= HCS_CHAN_MAX;
	endsequence
	property p_reply;
		ce && req.valid |=> rsp.valid && rsp.chan == $past(req.chan)
			&& rsp.count == 8'h01 && rsp.handle == 8'h00;
	endproperty
	a_reply: assert property (p_reply) else $error("bad reply frame");
	property p_quiet;
		ce && !req.valid |=> !rsp.valid;
	endproperty
	a_quiet: assert property (p_quiet) else $error("reply without request");
	property p_bad;
		ce && req.valid && req.chan > 8'h03 && req.chan != 8'hff |=> rsp.status == 8'h35;
	endproperty
	a_bad: assert property (p_bad) else $error("bad channel accepted");
	property p_info;
		s_req(HCS_CMD_DEVINFO) ##0 chan_st.info_avail[c] |=> rsp.status == 8'h00;
	endproperty
	a_info: assert property (p_info) else $error("info not success");
	property p_run;
		s_req(HCS_CMD_DEVINFO) ##0 (!chan_st.info_avail[c] && lk[c] && chan_st.gathering[c])
			|=> rsp.status == 8'h34;
	endproperty
	a_run: assert property (p_run) else $error("gathering not reported");
	property p_susp;
		s_req(8'h05) ##0 (ok[c] && !cfg_change[c])
			|=> rsp.status == 8'h00 && ch_suspended[$past(c)];
	endproperty
	a_susp: assert property (p_susp) else $error("suspend failed");
	property p_deny;
		s_req(8'h06) ##0 !ok[c] |=> rsp.status == 8'h35;
	endproperty
	a_deny: assert property (p_deny) else $error("resume not refused");
	property p_cfg;
		ce && cfg_change != 4'h0 |=> (ch_suspended & $past(cfg_change)) == 4'h0
			&& (ch_fp_reset & $past(cfg_change)) == $past(cfg_change);
	endproperty
	a_cfg: assert property (p_cfg) else $error("config change ignored");
	property p_auto;
		n_q <= LIM;
	endproperty
	a_auto: assert property (p_auto) else $error("suspension too long");
endmodule // hcs_top_chk

bind hcs_top hcs_top_chk #(.SUSP_CYCLES(SUSP_CYCLES)) chk (
	.mclk(mclk), .arst_n(arst_n), .ce(ce), .req(req), .chan_st(chan_st),
	.oimg_suspend(oimg_suspend), .cfg_change(cfg_change), .passthru_req(passthru_req),
	.rsp(rsp), .ch_suspended(ch_suspended), .ch_fp_reset(ch_fp_reset)
);

// file: sim/tb.sv
// self-checking bench for the channel service command interpreter
`timescale 1ns/10ps
module tb;
	import hcs_pkg::*;
	localparam logic [HCS_TMR_W-1:0] SC = 36'h14;
	logic       mclk = 1'b0;
	logic       arst_n = 1'b0;
	logic       ce = 1'b1;
	hcs_req_t   req;
	hcs_rsp_t   rsp;
	hcs_rsp_t   r;
	hcs_chan_t  cs = '0;
	logic [3:0] oimg = 4'h0;
	logic [3:0] cfg = 4'h0;
	logic [3:0] pt = 4'h0;
	logic [3:0] susp;
	logic [3:0] fpr;
	int         n_errors = 0;
	int         num_checks = 0;
	always #2.5 mclk = ~mclk;
	hcs_top #(.SUSP_CYCLES(SC)) uut (
		.mclk(mclk), .arst_n(arst_n), .ce(ce), .req(req), .chan_st(cs),
		.oimg_suspend(oimg), .cfg_change(cfg), .passthru_req(pt),
		.rsp(rsp), .ch_suspended(susp), .ch_fp_reset(fpr)
	);
	hcs_host_model host (.mclk(mclk), .rsp(rsp), .req(req));
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string m);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task automatic rq(input logic [7:0] ch, input logic [7:0] c, input logic [7:0] st);
		host.xfer(ch, c, r);
		cmp(8'(r.valid), 8'h01, "reply valid");
		cmp(r.chan, ch, "channel echo");
		cmp(r.status, st, "status");
		cmp(r.count, 8'h01, "count");
		cmp(r.handle, 8'h00, "handle");
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic t_info;
		cs = '{4'hb, 4'h3, 4'h2, 4'h1};
		rq(8'h00, HCS_CMD_DEVINFO, 8'h00);
		rq(8'h01, HCS_CMD_DEVINFO, 8'h34);
		rq(8'h02, HCS_CMD_DEVINFO, 8'h35);
		rq(8'h03, HCS_CMD_DEVINFO, 8'h35);
		rq(8'h04, HCS_CMD_DEVINFO, 8'h35);
		rq(8'h00, 8'h07, 8'h35);
		rq(8'h81, 8'h05, 8'h35);
		$display("t_info done");
	endtask
	task automatic t_susp;
		cs = '{4'hf, 4'h7, 4'h4, 4'h0};
		rq(8'h00, 8'h05, 8'h00);
		rq(8'h00, 8'h05, 8'h00);
		rq(8'h02, 8'h05, 8'h35);
		rq(8'h03, 8'h06, 8'h35);
		rq(8'h01, 8'h06, 8'h00);
		cmp(8'(susp), 8'h01, "suspend state");
		rq(8'h00, 8'h06, 8'h00);
		rq(8'hff, 8'h05, 8'h00);
		cmp(8'(susp), 8'h03, "all suspend");
		cfg = 4'h2;
		@(posedge mclk);
		#1 cfg = 4'h0;
		cmp(8'(fpr), 8'h02, "field reset");
		cmp(8'(susp), 8'h01, "config clears");
		rq(8'hff, 8'h06, 8'h00);
		cmp(8'(susp), 8'h00, "all resume");
		$display("t_susp done");
	endtask
	task automatic t_auto;
		int n;
		cs = '{4'hf, 4'hf, 4'h0, 4'h0};
		rq(8'h00, 8'h05, 8'h00);
		n = 0;
		while (susp[0] === 1'b1 && n < 100) begin
			@(posedge mclk);
			#1 pt[0] = (n == 9);
			n++;
		end
		if (n >= 100) begin
			n_errors++;
			wrap_up();
		end else begin
			// reload at cycle ten moves the end past the plain period
			cmp(8'(n >= int'(SC) + 6 && n <= int'(SC) + 16), 8'h01, "auto resume");
		end
		$display("t_auto done");
	endtask
	task automatic t_ce;
		ce = 1'b0;
		oimg[1] = 1'b1;
		repeat (3) @(posedge mclk);
		#1;
		cmp(8'(susp), 8'h00, "frozen image");
		ce = 1'b1;
		repeat (2) @(posedge mclk);
		#1;
		cmp(8'(susp), 8'h02, "image after enable");
		// a frozen timer must not end the suspension
		ce = 1'b0;
		repeat (30) @(posedge mclk);
		#1;
		cmp(8'(susp), 8'h02, "timer frozen");
		ce = 1'b1;
		oimg[1] = 1'b0;
		repeat (2) @(posedge mclk);
		#1;
		cmp(8'(susp), 8'h00, "image resume after enable");
		$display("t_ce done");
	endtask
	task automatic t_pwr;
		rq(8'h00, HCS_CMD_SUSPEND, 8'h00);
		arst_n = 1'b0;
		@(posedge mclk);
		#1;
		cmp(8'(susp), 8'h00, "power-up clears");
		cmp(8'(rsp.valid), 8'h00, "reset quiet");
		arst_n = 1'b1;
		repeat (3) @(posedge mclk);
		rq(8'h00, HCS_CMD_RESUME, 8'h00);
		cmp(8'(susp), 8'h00, "resume ignored after reset");
		$display("t_pwr done");
	endtask
	task automatic t_img;
		@(posedge mclk);
		#1 oimg[2] = 1'b1;
		repeat (2) @(posedge mclk);
		#1;
		cmp(8'(susp), 8'h04, "image suspend");
		cmp(8'(rsp.valid), 8'h00, "image silent");
		oimg[2] = 1'b0;
		repeat (2) @(posedge mclk);
		#1;
		cmp(8'(susp), 8'h00, "image resume");
		$display("t_img done");
	endtask
	initial begin
		repeat (4) @(posedge mclk);
		#1 arst_n = 1'b1;
		repeat (3) @(posedge mclk);
		t_info();
		t_susp();
		t_auto();
		t_img();
		t_ce();
		t_pwr();
		wrap_up();
	end
endmodule // tb

// file: src/hcs_pkg.sv
// package for the channel service command logic: codes, layouts and timing
package hcs_pkg;

	localparam int          HCS_NCH          = 4;
	localparam logic [7:0]  HCS_CHAN_MAX     = 8'h03;
	localparam logic [7:0]  HCS_CHAN_ALL     = 8'hff;

	localparam logic [7:0]  HCS_CMD_DEVINFO  = 8'h02;
	localparam logic [7:0]  HCS_CMD_SUSPEND  = 8'h05;
	localparam logic [7:0]  HCS_CMD_RESUME   = 8'h06;

	localparam logic [7:0]  HCS_ST_SUCCESS                  = 8'h00;
	localparam logic [7:0]  HCS_ST_GATHERING_IN_PROGRESS_CODE = 8'h34;
	localparam logic [7:0]  HCS_ST_REQUEST_REJECTED_CODE      = 8'h35;

	localparam logic [7:0]  HCS_RSP_COUNT    = 8'h01;
	localparam logic [7:0]  HCS_RSP_HANDLE   = 8'h00;

	localparam longint      HCS_CLK_HZ       = 64'd200000000;
	localparam longint      HCS_SUSP_TIME_S  = 64'd180;
	localparam int          HCS_TMR_W        = 36;
	localparam logic [HCS_TMR_W-1:0] HCS_SUSP_CYCLES =
		HCS_TMR_W'(HCS_SUSP_TIME_S * HCS_CLK_HZ);

	typedef struct packed {
		logic       valid;
		logic [7:0] chan;
		logic [7:0] cmd;
	} hcs_req_t;

	typedef struct packed {
		logic       valid;
		logic [7:0] chan;
		logic [7:0] status;
		logic [7:0] count;
		logic [7:0] handle;
	} hcs_rsp_t;

	typedef struct packed {
		logic [HCS_NCH-1:0] enabled;
		logic [HCS_NCH-1:0] linked;
		logic [HCS_NCH-1:0] gathering;
		logic [HCS_NCH-1:0] info_avail;
	} hcs_chan_t;

	typedef enum logic {
		HCS_CH_RUN,
		HCS_CH_SUSP
	} hcs_chst_t;

endpackage

// file: src/hcs_resume_timer.sv
// down counter that ends a channel suspension after a fixed time
`timescale 1ns/10ps
module hcs_resume_timer #(
	parameter int                 W      = 36,
	parameter logic [W-1:0]       CYCLES = '1
) (
	input  wire logic             clk,     // system clock
	input  wire logic             rst_n,   // synchronised reset, active low
	input  wire logic             ce,      // clock enable
	input  wire logic             load,    // start or restart full period
	input  wire logic             clear,   // abandon the period
	output logic                  expire   // one-cycle pulse at end of period
);

	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;
	logic         run_q;
	logic         run_d;
	logic         exp_q;
	logic         exp_d;

	always_comb begin
		cnt_d = cnt_q;
		run_d = run_q;
		exp_d = 1'b0;
		if (clear) begin
			run_d = 1'b0;
		end else if (load) begin
			cnt_d = CYCLES;
			run_d = 1'b1;
		end else if (run_q) begin
			if (cnt_q <= W'(1)) begin
				run_d = 1'b0;
				exp_d = 1'b1;
			end else begin
				cnt_d = cnt_q - W'(1);
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= '0;
			run_q <= 1'b0;
			exp_q <= 1'b0;
		end else if (ce) begin
			cnt_q <= cnt_d;
			run_q <= run_d;
			exp_q <= exp_d;
		end
	end

	assign expire = exp_q & ce;

endmodule // hcs_resume_timer

// file: src/hcs_top.sv
// channel service command interpreter: device-info status and suspend/resume
//
// Overview of operation
// - device-info request answers success when command, channel valid and info available.
// - device-info answers running when enabled, linked and already gathering; nothing started.
// - device-info answers rejected for bad command or channel, disabled, unlinked, otherwise.
// - suspend on an enabled channel keeps configuration and halts its field traffic.
// - configuration change overrides suspension and resets field function; suspension not kept.
// - resume on a suspended channel restores normal field operation.
// - output image bit also requests suspend or resume, handled like the command.
// - resume on a channel that is not suspended is ignored.
// - suspension ends automatically after three minutes; pass-through reloads full period.
// - first request byte is channel 0 to 3, or all-ones for every channel.
// - second request byte 0x05 suspends, 0x06 resumes.
// - suspend/resume reply echoes channel, then status, count one, handle zero.
// - suspend/resume status is 00 success or 35 rejected, state at receipt.
// - suspend/resume succeeds when valid, enabled and start-up connection finished.
// - pairing of suspend and resume is not checked; repeat suspend still succeeds.
// - suspend/resume rejected when disabled, unlinked, still gathering, or otherwise.
// - device-info status codes are 34 for running and 35 for rejected.
// - every reply carries status as second byte after the echoed channel.
`timescale 1ns/10ps
module hcs_top #(
	parameter logic [hcs_pkg::HCS_TMR_W-1:0] SUSP_CYCLES = hcs_pkg::HCS_SUSP_CYCLES
) (
	input  wire logic                        mclk,          // 200 MHz system clock
	input  wire logic                        arst_n,        // async reset, active low
	input  wire logic                        ce,            // clock enable, freezes state
	input  wire hcs_pkg::hcs_req_t           req,           // request packet, valid one cycle
	input  wire hcs_pkg::hcs_chan_t          chan_st,       // per-channel field state
	input  wire logic [hcs_pkg::HCS_NCH-1:0] oimg_suspend,  // output image suspend bits
	input  wire logic [hcs_pkg::HCS_NCH-1:0] cfg_change,    // configuration change pulses
	input  wire logic [hcs_pkg::HCS_NCH-1:0] passthru_req,  // pass-through request pulses
	output hcs_pkg::hcs_rsp_t                rsp,           // reply packet, valid one cycle
	output logic [hcs_pkg::HCS_NCH-1:0]      ch_suspended,  // channel field traffic halted
	output logic [hcs_pkg::HCS_NCH-1:0]      ch_fp_reset    // field function reset pulse
);
	import hcs_pkg::*;

	// reset release
	logic rst_s1_q;
	logic rst_n_q;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rst_s1_q <= 1'b0;
			rst_n_q  <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n_q  <= rst_s1_q;
		end
	end

	// decoding for the command path; sr_ready also serves the image path
	function automatic logic chan_single(input logic [7:0] c);
		chan_single = (c <= HCS_CHAN_MAX);
	endfunction

	function automatic logic chan_legal(input logic [7:0] c);
		chan_legal = chan_single(c) || (c == HCS_CHAN_ALL);
	endfunction

	function automatic logic sr_ready(input hcs_chan_t s, input int i);
		sr_ready = s.enabled[i] && s.linked[i] && !s.gathering[i];
	endfunction

	// per-channel targeting of the current request
	logic [HCS_NCH-1:0] tgt;
	logic [HCS_NCH-1:0] ok;
	logic               is_sr;
	logic               is_susp;
	logic               is_res;
	logic               is_info;

	always_comb begin
		is_susp = req.valid && (req.cmd == HCS_CMD_SUSPEND);
		is_res  = req.valid && (req.cmd == HCS_CMD_RESUME);
		is_info = req.valid && (req.cmd == HCS_CMD_DEVINFO);
		is_sr   = is_susp || is_res;
		for (int i = 0; i < HCS_NCH; i++) begin
			tgt[i] = (req.chan == HCS_CHAN_ALL) ||
				(chan_single(req.chan) && (req.chan[1:0] == 2'(i)));
			ok[i]  = tgt[i] && sr_ready(chan_st, i);
		end
	end

	// output image edges act like commands
	logic [HCS_NCH-1:0] oimg_q;
	logic [HCS_NCH-1:0] oimg_d;
	logic [HCS_NCH-1:0] img_susp;
	logic [HCS_NCH-1:0] img_res;

	always_comb begin
		oimg_d = oimg_suspend;
		for (int i = 0; i < HCS_NCH; i++) begin
			img_susp[i] = oimg_suspend[i] && !oimg_q[i] && sr_ready(chan_st, i);
			img_res[i]  = !oimg_suspend[i] && oimg_q[i] && sr_ready(chan_st, i);
		end
	end

	always_ff @(posedge mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			oimg_q <= '0;
		end else if (ce) begin
			oimg_q <= oimg_d;
		end
	end

	// per-channel suspension state and automatic resume
	hcs_chst_t          st_q [HCS_NCH];
	hcs_chst_t          st_d [HCS_NCH];
	logic [HCS_NCH-1:0] do_susp;
	logic [HCS_NCH-1:0] do_res;
	logic [HCS_NCH-1:0] tmr_load;
	logic [HCS_NCH-1:0] tmr_clear;
	logic [HCS_NCH-1:0] tmr_exp;
	logic [HCS_NCH-1:0] susp_d;
	logic [HCS_NCH-1:0] susp_q;
	logic [HCS_NCH-1:0] fpr_d;
	logic [HCS_NCH-1:0] fpr_q;

	genvar g;
	generate
		for (g = 0; g < HCS_NCH; g++) begin : g_ch
			hcs_resume_timer #(
				.W      (HCS_TMR_W),
				.CYCLES (SUSP_CYCLES)
			) u_tmr (
				.clk    (mclk),
				.rst_n  (rst_n_q),
				.ce     (ce),
				.load   (tmr_load[g]),
				.clear  (tmr_clear[g]),
				.expire (tmr_exp[g])
			);
		end
	endgenerate

	always_comb begin
		for (int i = 0; i < HCS_NCH; i++) begin
			// repeat suspend simply succeeds again and restarts the period
			do_susp[i] = (is_susp && ok[i]) || img_susp[i];
			do_res[i]  = ((is_res && ok[i]) || img_res[i]) && !do_susp[i];
			st_d[i]    = st_q[i];
			tmr_load[i]  = 1'b0;
			tmr_clear[i] = 1'b0;
			fpr_d[i]   = cfg_change[i];
			if (cfg_change[i]) begin
				// configuration change outranks any pending service request
				st_d[i]      = HCS_CH_RUN;
				tmr_clear[i] = 1'b1;
			end else begin
				case (st_q[i])
					HCS_CH_RUN: begin
						// resume while running falls through untouched
						if (do_susp[i]) begin
							st_d[i]     = HCS_CH_SUSP;
							tmr_load[i] = 1'b1;
						end
					end
					HCS_CH_SUSP: begin
						if (do_susp[i] || passthru_req[i]) begin
							tmr_load[i] = 1'b1;
						end else if (do_res[i]) begin
							st_d[i]      = HCS_CH_RUN;
							tmr_clear[i] = 1'b1;
						end else if (tmr_exp[i]) begin
							st_d[i] = HCS_CH_RUN;
						end
					end
					default: begin
						st_d[i] = HCS_CH_RUN;
					end
				endcase
			end
			susp_d[i] = (st_d[i] == HCS_CH_SUSP);
		end
	end

	always_ff @(posedge mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			// power-up never inherits a suspension
			for (int i = 0; i < HCS_NCH; i++) begin
				st_q[i] <= HCS_CH_RUN;
			end
			susp_q <= '0;
			fpr_q  <= '0;
		end else if (ce) begin
			for (int i = 0; i < HCS_NCH; i++) begin
				st_q[i] <= st_d[i];
			end
			susp_q <= susp_d;
			fpr_q  <= fpr_d;
		end
	end

	// reply builder; status judged from state at the cycle of receipt
	hcs_rsp_t rsp_d;
	hcs_rsp_t rsp_q;
	logic     info_chan_ok;
	logic [1:0] ci;

	always_comb begin
		ci           = req.chan[1:0];
		info_chan_ok = chan_single(req.chan);
		rsp_d        = '0;
		rsp_d.valid  = req.valid;
		rsp_d.chan   = req.chan;
		rsp_d.count  = HCS_RSP_COUNT;
		rsp_d.handle = HCS_RSP_HANDLE;
		rsp_d.status = HCS_ST_REQUEST_REJECTED_CODE;
		if (is_info && info_chan_ok) begin
			if (chan_st.info_avail[ci]) begin
				rsp_d.status = HCS_ST_SUCCESS;
			end else if (chan_st.enabled[ci] && chan_st.linked[ci] &&
				chan_st.gathering[ci]) begin
				// only reports; no gathering is started from here
				rsp_d.status = HCS_ST_GATHERING_IN_PROGRESS_CODE;
			end
		end else if (is_sr && chan_legal(req.chan) && (|ok)) begin
			rsp_d.status = HCS_ST_SUCCESS;
		end
	end

	always_ff @(posedge mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			rsp_q <= '0;
		end else if (ce) begin
			rsp_q <= rsp_d;
		end
	end

	assign rsp          = rsp_q;
	assign ch_suspended = susp_q;
	assign ch_fp_reset  = fpr_q;

endmodule // hcs_top
